// *** design/jrlec_pkg.sv ***
// constants shared by the lane error control block
package jrlec_pkg;
	// register addresses
	localparam logic [7:0] ERR_HANDLING_ADDR = 8'hdb;
	localparam logic [7:0] RESTART_CTRL_ADDR = 8'hdc;
	localparam logic [7:0] LANE_MISC_ADDR    = 8'hdd;
	localparam logic [7:0] GEOMETRY_ADDR     = 8'hde;
	// reset values
	localparam logic [7:0] ERR_HANDLING_RST  = 8'h00;
	localparam logic [7:0] RESTART_CTRL_RST  = 8'h00;
	localparam logic [7:0] LANE_MISC_RST     = 8'h00;
	localparam logic [7:0] GEOMETRY_RST      = 8'h00;
	// lane_error_handling fields
	localparam int FWD_EN_LSB   = 4;
	localparam int CONCEAL_BIT  = 3;
	localparam int CLASS_LSB    = 0;
	localparam int TABLE_IGN_BIT     = 0;
	localparam int DISPARITY_IGN_BIT = 1;
	// lane_reinit_control fields
	localparam int RESTART_LSB  = 4;
	localparam int RESYNC_LSB   = 0;
	// lane_misc_control fields
	localparam int STROBE_BIT   = 7;
	localparam logic [7:0] MISC_RSVD_MASK = 8'h03;
	// link_geometry_control fields
	localparam int LANES_LSB    = 5;
	localparam int CONV_LSB     = 3;
	localparam int OCTETS_LSB   = 0;
	// field codes hold count minus one
	localparam logic [2:0] LANES_1  = 3'h0;
	localparam logic [2:0] LANES_2  = 3'h1;
	localparam logic [2:0] LANES_4  = 3'h3;
	localparam logic [1:0] CONV_ONE = 2'h0;
	localparam logic [2:0] OCTETS_1 = 3'h0;
	localparam logic [2:0] OCTETS_2 = 3'h1;
	localparam logic [2:0] OCTETS_4 = 3'h3;
	// comma control symbol
	localparam logic [7:0] K28_5    = 8'hbc;

	typedef enum logic {
		JRLEC_CAP_IDLE = 1'b0,
		JRLEC_CAP_WAIT = 1'b1
	} jrlec_cap_t;
endpackage

// *** design/jrlec_buf2.sv ***
// two-entry valid/ready buffer on the link clock
`timescale 1ns/1ps
module jrlec_buf2 #(
	parameter int W = 68
) (
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire logic         ce_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic              wp;
		logic              rp;
		logic [1:0]        cnt;
	} jrlec_buf_t;

	jrlec_buf_t s, n;
	logic push, pop;

	assign in_ready_o  = (s.cnt != 2'h2);
	assign out_valid_o = (s.cnt != 2'h0);
	assign out_data_o  = s.mem[s.rp];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_comb begin
		n = s;
		if (ce_i) begin
			if (push) begin
				n.mem[s.wp] = in_data_i;
				n.wp        = ~s.wp;
			end
			if (pop) begin
				n.rp = ~s.rp;
			end
			if (push && !pop) begin
				n.cnt = s.cnt + 2'h1;
			end else if (pop && !push) begin
				n.cnt = s.cnt - 2'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule

// *** design/jrlec_lane_ctrl.sv ***
// receive lane error handling, restart, resync and sample capture
//
// What this block does
// R1 - per physical lane enable bits 7..4 forward not-in-table errors to frame assembler
// R2 - conceal bad sample: bit 3 low repeats one sample, high repeats two
// R3 - class field: 00 both used, 01 drop table errors, 10 drop disparity, 11 both
// R4 - logical lane bits 7..4: alignment buffer out-of-range requests link reinitialization
// R5 - physical lane bits 3..0: watch stream for K28.5 and request resync
// R6 - writing strobe bit 7 as 1 captures a fresh 16-bit sample per lane
// R7 - geometry bits 7..5 set active lane count: 1, 2 or 4
// R8 - geometry bits 4..3 set converter count; one value only is supported
// R9 - geometry bits 2..0 set octets per frame: 1, 2 or 4
// R10 - an ignored error class neither conceals nor forwards
`timescale 1ns/1ps
module jrlec_lane_ctrl #(
	parameter int LANES = 4,
	parameter int SW    = 16
) (
	input  wire logic                     clk_i,
	input  wire logic                     reset_i,
	input  wire logic                     ce_i,
	input  wire logic                     reg_wr_i,
	input  wire logic [7:0]               reg_addr_i,
	input  wire logic [7:0]               reg_wdata_i,
	output logic [7:0]                    reg_rdata_o,
	output logic [LANES-1:0]              reinit_request_o,
	output logic [LANES-1:0]              resync_request_o,
	output logic [LANES-1:0][SW-1:0]      capture_sample_o,
	output logic                          capture_done_o,
	output logic                          geometry_ok_o,
	output logic [LANES-1:0]              active_lanes_o,
	input  wire logic                     link_clk_i,
	input  wire logic                     link_valid_i,
	output logic                          link_ready_o,
	input  wire logic [LANES-1:0][SW-1:0] link_word_i,
	input  wire logic [LANES-1:0][1:0]    link_k_i,
	input  wire logic [LANES-1:0][1:0]    not_in_table_error_i,
	input  wire logic [LANES-1:0][1:0]    disparity_error_i,
	input  wire logic [LANES-1:0]         align_range_error_i,
	output logic                          sample_valid_o,
	input  wire logic                     sample_ready_i,
	output logic [LANES-1:0][SW-1:0]      sample_data_o,
	output logic [LANES-1:0]              sample_not_in_table_forward_o
);
	localparam int BW = LANES * SW + LANES;

	function automatic logic [LANES-1:0] lane_mask(input logic [7:0] geo);
		logic [2:0] code;
		code = geo[jrlec_pkg::LANES_LSB +: 3];
		case (code)
			jrlec_pkg::LANES_1: lane_mask = LANES'(4'h1);
			jrlec_pkg::LANES_2: lane_mask = LANES'(4'h3);
			jrlec_pkg::LANES_4: lane_mask = LANES'(4'hf);
			default:            lane_mask = '0;
		endcase
	endfunction

	function automatic logic geo_ok(input logic [7:0] geo);
		logic [2:0] f;
		f = geo[jrlec_pkg::OCTETS_LSB +: 3];
		geo_ok = (lane_mask(geo) != '0)
			&& (geo[jrlec_pkg::CONV_LSB +: 2] == jrlec_pkg::CONV_ONE)
			&& (f == jrlec_pkg::OCTETS_1 || f == jrlec_pkg::OCTETS_2
			|| f == jrlec_pkg::OCTETS_4);
	endfunction

	// system clock domain state
	typedef struct packed {
		logic [7:0]              err_q;
		logic [7:0]              reinit_q;
		logic [7:0]              misc_q;
		logic [7:0]              geo_q;
		logic [7:0]              rdata;
		jrlec_pkg::jrlec_cap_t   cap;
		logic                    req_tgl;
		logic [2:0]              ack_sy;
		logic [LANES-1:0]        ri_s1;
		logic [LANES-1:0]        ri_s2;
		logic [LANES-1:0]        ri_s3;
		logic [LANES-1:0]        rs_s1;
		logic [LANES-1:0]        rs_s2;
		logic [LANES-1:0]        rs_s3;
		logic [LANES-1:0]        ri_pulse;
		logic [LANES-1:0]        rs_pulse;
		logic [LANES-1:0][SW-1:0] cap_data;
		logic                    cap_done;
		logic                    geo_good;
		logic [LANES-1:0]        active;
	} jrlec_sys_t;

	// link clock domain state
	typedef struct packed {
		logic [23:0]              cfg_s1;
		logic [23:0]              cfg_s2;
		logic                     ce_s1;
		logic                     ce_s2;
		logic [2:0]               req_sy;
		logic [LANES-1:0][SW-1:0] h1;
		logic [LANES-1:0][SW-1:0] h2;
		logic [LANES-1:0][SW-1:0] hold;
		logic                     ack_tgl;
		logic [LANES-1:0]         ri_tgl;
		logic [LANES-1:0]         rs_tgl;
	} jrlec_link_t;

	jrlec_sys_t  s, sn;
	jrlec_link_t l, ln;
	logic [1:0]  lrst_q;
	logic        lrst;

	logic                     buf_in_valid;
	logic                     buf_in_ready;
	logic [BW-1:0]            buf_in_data;
	logic [BW-1:0]            buf_out_data;
	logic [LANES-1:0][SW-1:0] cur_sample;
	logic [LANES-1:0]         cur_fwd;

	// ---------------- system domain ----------------
	always_comb begin
		sn = s;
		sn.cap_done = 1'b0;
		if (ce_i) begin
			sn.ack_sy = {s.ack_sy[1:0], l.ack_tgl};
			sn.ri_s1  = l.ri_tgl;
			sn.ri_s2  = s.ri_s1;
			sn.ri_s3  = s.ri_s2;
			sn.rs_s1  = l.rs_tgl;
			sn.rs_s2  = s.rs_s1;
			sn.rs_s3  = s.rs_s2;
			sn.ri_pulse = s.ri_s2 ^ s.ri_s3; // [R4]
			sn.rs_pulse = s.rs_s2 ^ s.rs_s3; // [R5]
			if (reg_wr_i) begin
				case (reg_addr_i)
					jrlec_pkg::ERR_HANDLING_ADDR: sn.err_q    = reg_wdata_i;
					jrlec_pkg::RESTART_CTRL_ADDR: sn.reinit_q = reg_wdata_i;
					jrlec_pkg::LANE_MISC_ADDR: begin
						sn.misc_q = reg_wdata_i & jrlec_pkg::MISC_RSVD_MASK;
					end
					jrlec_pkg::GEOMETRY_ADDR:     sn.geo_q    = reg_wdata_i;
					default:                      sn.geo_q    = s.geo_q;
				endcase
			end
			case (s.cap)
				jrlec_pkg::JRLEC_CAP_IDLE: begin
					if (reg_wr_i && reg_addr_i == jrlec_pkg::LANE_MISC_ADDR
						&& reg_wdata_i[jrlec_pkg::STROBE_BIT]) begin
						sn.req_tgl = ~s.req_tgl; // [R6]
						sn.cap     = jrlec_pkg::JRLEC_CAP_WAIT;
					end
				end
				jrlec_pkg::JRLEC_CAP_WAIT: begin
					if (s.ack_sy[2] != s.ack_sy[1]) begin
						sn.cap_data = l.hold; // [R6]
						sn.cap_done = 1'b1;
						sn.cap      = jrlec_pkg::JRLEC_CAP_IDLE;
					end
				end
				default: sn.cap = jrlec_pkg::JRLEC_CAP_IDLE;
			endcase
			sn.misc_q[jrlec_pkg::STROBE_BIT] = (sn.cap == jrlec_pkg::JRLEC_CAP_WAIT);
			sn.geo_good = geo_ok(s.geo_q); // [R7] [R8] [R9]
			sn.active   = lane_mask(s.geo_q); // [R7]
			case (reg_addr_i)
				jrlec_pkg::ERR_HANDLING_ADDR: sn.rdata = s.err_q;
				jrlec_pkg::RESTART_CTRL_ADDR: sn.rdata = s.reinit_q;
				jrlec_pkg::LANE_MISC_ADDR:    sn.rdata = s.misc_q;
				jrlec_pkg::GEOMETRY_ADDR:     sn.rdata = s.geo_q;
				default:                      sn.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s          <= '0;
			s.err_q    <= jrlec_pkg::ERR_HANDLING_RST;
			s.reinit_q <= jrlec_pkg::RESTART_CTRL_RST;
			s.misc_q   <= jrlec_pkg::LANE_MISC_RST;
			s.geo_q    <= jrlec_pkg::GEOMETRY_RST;
			s.cap      <= jrlec_pkg::JRLEC_CAP_IDLE;
		end else begin
			s <= sn;
		end
	end

	assign reg_rdata_o      = s.rdata;
	assign reinit_request_o = s.ri_pulse;
	assign resync_request_o = s.rs_pulse;
	assign capture_sample_o = s.cap_data;
	assign capture_done_o   = s.cap_done;
	assign geometry_ok_o    = s.geo_good;
	assign active_lanes_o   = s.active;

	// ---------------- link domain ----------------
	// reset carried into the link clock
	always_ff @(posedge link_clk_i) begin
		lrst_q <= {lrst_q[0], reset_i};
	end
	assign lrst = lrst_q[1];

	always_comb begin
		logic [7:0]       e_reg;
		logic [LANES-1:0] act;
		logic             nit_use;
		logic             bad;
		e_reg   = l.cfg_s2[23:16];
		act     = lane_mask(l.cfg_s2[7:0]);
		nit_use = 1'b0;
		bad     = 1'b0;
		cur_sample = link_word_i;
		cur_fwd    = '0;
		for (int i = 0; i < LANES; i++) begin
			nit_use = act[i] && (|not_in_table_error_i[i])
				&& !e_reg[jrlec_pkg::TABLE_IGN_BIT]; // [R3] [R10]
			bad = nit_use || (act[i] && (|disparity_error_i[i])
				&& !e_reg[jrlec_pkg::DISPARITY_IGN_BIT]); // [R3] [R10]
			cur_fwd[i] = nit_use && e_reg[jrlec_pkg::FWD_EN_LSB + i]; // [R1]
			if (bad) begin
				cur_sample[i] = e_reg[jrlec_pkg::CONCEAL_BIT] ? l.h2[i] : l.h1[i]; // [R2]
			end
		end
	end

	assign buf_in_valid = link_valid_i && l.ce_s2;
	assign buf_in_data  = {cur_fwd, cur_sample};
	assign link_ready_o = buf_in_ready;

	always_comb begin
		logic [7:0] r_reg;
		logic [LANES-1:0] act;
		r_reg  = l.cfg_s2[15:8];
		act    = lane_mask(l.cfg_s2[7:0]);
		ln     = l;
		ln.cfg_s1 = {s.err_q, s.reinit_q, s.geo_q};
		ln.cfg_s2 = l.cfg_s1;
		ln.ce_s1  = ce_i;
		ln.ce_s2  = l.ce_s1;
		if (l.ce_s2) begin
			ln.req_sy = {l.req_sy[1:0], s.req_tgl};
			if (buf_in_valid && buf_in_ready) begin
				ln.h1 = cur_sample; // [R2]
				ln.h2 = l.h1;
			end
			if (l.req_sy[2] != l.req_sy[1]) begin
				ln.hold    = l.h1; // [R6]
				ln.ack_tgl = ~l.ack_tgl;
			end
			for (int i = 0; i < LANES; i++) begin
				if (act[i] && align_range_error_i[i]
					&& r_reg[jrlec_pkg::RESTART_LSB + i]) begin
					ln.ri_tgl[i] = ~l.ri_tgl[i]; // [R4]
				end
				if (link_valid_i && r_reg[jrlec_pkg::RESYNC_LSB + i]
					&& ((link_k_i[i][0] && link_word_i[i][7:0] == jrlec_pkg::K28_5)
					|| (link_k_i[i][1] && link_word_i[i][15:8] == jrlec_pkg::K28_5))) begin
					ln.rs_tgl[i] = ~l.rs_tgl[i]; // [R5]
				end
			end
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			l <= '0;
		end else begin
			l <= ln;
		end
	end

	jrlec_buf2 #(
		.W (BW)
	) u_buf (
		.clk_i       (link_clk_i),
		.reset_i     (lrst),
		.ce_i        (l.ce_s2),
		.in_valid_i  (buf_in_valid),
		.in_ready_o  (buf_in_ready),
		.in_data_i   (buf_in_data),
		.out_valid_o (sample_valid_o),
		.out_ready_i (sample_ready_i),
		.out_data_o  (buf_out_data)
	);

	assign sample_data_o        = buf_out_data[LANES*SW-1:0];
	assign sample_not_in_table_forward_o = buf_out_data[BW-1 -: LANES];
endmodule

// *** sim/jrlec_lane_ctrl_assertions.sv ***
// concurrent checks on the lane error control ports
`timescale 1ns/1ps
module jrlec_lane_ctrl_assertions #(
	parameter int LANES = 4,
	parameter int SW    = 16
) (
	input wire logic                     clk_i,
	input wire logic                     reset_i,
	input wire logic                     ce_i,
	input wire logic                     reg_wr_i,
	input wire logic [7:0]               reg_addr_i,
	input wire logic [7:0]               reg_wdata_i,
	input wire logic [LANES-1:0]         reinit_request_o,
	input wire logic [LANES-1:0]         resync_request_o,
	input wire logic [LANES-1:0][SW-1:0] capture_sample_o,
	input wire logic                     capture_done_o,
	input wire logic                     geometry_ok_o,
	input wire logic [LANES-1:0]         active_lanes_o,
	input wire logic                     link_clk_i,
	input wire logic                     sample_valid_o,
	input wire logic                     sample_ready_i,
	input wire logic [LANES-1:0][SW-1:0] sample_data_o,
	input wire logic [LANES-1:0]         sample_not_in_table_forward_o
);
	logic [7:0] err_q, rin_q, geo_q;
	wire        wr = ce_i && reg_wr_i;
	// shadow of the written error handling, restart and geometry registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			err_q <= 8'h00;
			rin_q <= 8'h00;
			geo_q <= 8'h00;
		end else if (wr) begin
			if (reg_addr_i == 8'hdb) err_q <= reg_wdata_i;
			if (reg_addr_i == 8'hdc) rin_q <= reg_wdata_i;
			if (reg_addr_i == 8'hde) geo_q <= reg_wdata_i;
		end
	end
	function automatic logic [3:0] lmask(input logic [7:0] g);
		case (g[7:5])
			3'h0: lmask = 4'h1;
			3'h1: lmask = 4'h3;
			3'h3: lmask = 4'hf;
			default: lmask = 4'h0;
		endcase
	endfunction
	chk_geom_ok: assert property (@(posedge clk_i) disable iff (reset_i)
		wr && reg_addr_i == 8'hde |-> ##[1:3] geometry_ok_o == (lmask(geo_q) != 4'h0
		&& geo_q[4:3] == 2'h0 && geo_q[2:0] inside {3'h0, 3'h1, 3'h3}))
		else $error("geometry flag wrong");
	chk_lane_mask: assert property (@(posedge clk_i) disable iff (reset_i)
		wr && reg_addr_i == 8'hde |-> ##[2:4] active_lanes_o == lmask(geo_q))
		else $error("lane mask wrong");
	chk_cap_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
		capture_done_o |=> !capture_done_o)
		else $error("capture done too long");
	chk_cap_change: assert property (@(posedge clk_i) disable iff (reset_i)
		!$stable(capture_sample_o) |-> capture_done_o)
		else $error("capture data moved");
	chk_strobe_done: assert property (@(posedge clk_i) disable iff (reset_i)
		wr && reg_addr_i == 8'hdd && reg_wdata_i[7] |-> ##[1:60] capture_done_o)
		else $error("capture never done");
	chk_reinit_en: assert property (@(posedge clk_i) disable iff (reset_i)
		|reinit_request_o |-> (reinit_request_o & ~rin_q[7:4]) == 4'h0)
		else $error("reinit on disabled lane");
	chk_resync_en: assert property (@(posedge clk_i) disable iff (reset_i)
		|resync_request_o |-> (resync_request_o & ~rin_q[3:0]) == 4'h0)
		else $error("resync on disabled lane");
	chk_fwd_en: assert property (@(posedge clk_i) disable iff (reset_i)
		sample_valid_o |-> (sample_not_in_table_forward_o & ~(err_q[7:4] & {4{!err_q[0]}}))
		== 4'h0)
		else $error("forward not allowed");
	chk_buf_hold: assert property (@(posedge link_clk_i) disable iff (reset_i)
		sample_valid_o && !sample_ready_i |=> sample_valid_o && $stable(sample_data_o))
		else $error("stalled head lost");
	cov_cap: cover property (@(posedge clk_i) capture_done_o);
	cov_reinit: cover property (@(posedge clk_i) |reinit_request_o);
	cov_resync: cover property (@(posedge clk_i) |resync_request_o);
endmodule
bind jrlec_lane_ctrl jrlec_lane_ctrl_assertions #(.LANES(LANES), .SW(SW)) u_chk (.*);

// *** sim/jrlec_tx_model.sv ***
// transmitter model: offers one word per lane and holds it until taken
`timescale 1ns/1ps
module jrlec_tx_model (
	input  wire logic        link_clk_i,
	input  wire logic        link_ready_i,
	output logic             link_valid_o,
	output logic [3:0][15:0] word_o,
	output logic [3:0][1:0]  k_o,
	output logic [3:0][1:0]  table_err_o,
	output logic [3:0][1:0]  disparity_o,
	output logic [3:0]       range_o
);
	initial begin
		link_valid_o = 1'b0;
		word_o = 64'h0;
		k_o = 8'h00;
		table_err_o = 8'h00;
		disparity_o = 8'h00;
		range_o = 4'h0;
	end
	task automatic send(input logic [63:0] w, input logic [7:0] n = 8'h00, d = 8'h00,
			k = 8'h00, input logic [3:0] r = 4'h0);
		@(posedge link_clk_i);
		link_valid_o <= 1'b1;
		word_o <= w;
		k_o <= k;
		table_err_o <= n;
		disparity_o <= d;
		range_o <= r;
		do @(posedge link_clk_i); while (!link_ready_i);
		// idle word lines show the inverse so a stale word cannot pass
		link_valid_o <= 1'b0;
		word_o <= ~w;
		k_o <= 8'h00;
		table_err_o <= 8'h00;
		disparity_o <= 8'h00;
		range_o <= 4'h0;
	endtask
endmodule

// *** sim/jrlec_lane_ctrl_tb.sv ***
// self-checking bench for the lane error control block
`timescale 1ns/1ps
module jrlec_lane_ctrl_tb;
	logic             clk_i, reset_i, ce_i, reg_wr_i, link_clk_i, link_valid_i, link_ready_o;
	logic             capture_done_o, geometry_ok_o, sample_valid_o, sample_ready_i;
	logic [7:0]       reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [3:0]       reinit_request_o, resync_request_o, active_lanes_o, racc, sacc;
	logic [3:0]       align_range_error_i, sample_not_in_table_forward_o;
	logic [3:0][15:0] capture_sample_o, link_word_i, sample_data_o;
	logic [3:0][1:0]  link_k_i, not_in_table_error_i, disparity_error_i;
	logic [67:0]      rxq[$];
	int               error_cnt, comparisons, cdn;

	jrlec_lane_ctrl uut (.*);
	jrlec_tx_model far (.link_clk_i(link_clk_i), .link_ready_i(link_ready_o),
		.link_valid_o(link_valid_i), .word_o(link_word_i), .k_o(link_k_i),
		.table_err_o(not_in_table_error_i), .disparity_o(disparity_error_i),
		.range_o(align_range_error_i));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		link_clk_i = 1'b0;
		#3.7;
		forever #32 link_clk_i = ~link_clk_i;
	end
	always @(posedge clk_i) begin
		if (!reset_i) begin
			racc <= racc | reinit_request_o;
			sacc <= sacc | resync_request_o;
			if (capture_done_o === 1'b1) cdn <= cdn + 1;
		end
	end
	always @(posedge link_clk_i) begin
		if (sample_valid_o === 1'b1 && sample_ready_i)
			rxq.push_back({sample_not_in_table_forward_o, sample_data_o});
	end

	task automatic check(input logic [67:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		// let the settings cross into the link clock before the next word
		repeat (8) @(posedge clk_i);
	endtask
	task automatic rchk(input logic [7:0] a, d);
		@(posedge clk_i);
		reg_addr_i <= a;
		repeat (2) @(posedge clk_i);
		check(reg_rdata_o, d);
	endtask
	task automatic pop(input logic [67:0] e);
		for (int n = 0; n < 200 && rxq.size() == 0; n++) @(posedge clk_i);
		check((rxq.size() > 0) ? rxq.pop_front() : 68'hx, e);
	endtask
	function automatic logic [63:0] mk(input logic [15:0] v);
		mk = {v + 16'h3, v + 16'h2, v + 16'h1, v};
	endfunction
	task automatic give_verdict;
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#100us;
		error_cnt++;
		give_verdict();
	end
	initial begin
		logic [63:0] p, e, x;
		reset_i = 1'b1;
		ce_i = 1'b1;
		reg_wr_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		sample_ready_i = 1'b1;
		racc = 4'h0;
		sacc = 4'h0;
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		// link side leaves reset some link edges later
		repeat (40) @(posedge clk_i);
		#1;
		racc = 4'h0;
		sacc = 4'h0;
		for (int a = 8'hdb; a < 8'he0; a++) rchk(8'(a), 8'h00);
		wr(8'hdb, 8'hf9);
		rchk(8'hdb, 8'hf9);
		wr(8'hdc, 8'h12);
		rchk(8'hdc, 8'h12);
		wr(8'hdd, 8'h7f);
		rchk(8'hdd, 8'h03);
		for (int i = 0; i < 8; i++) begin
			wr(8'hde, {i[2:0], 5'h00});
			check(active_lanes_o, (i == 0) ? 4'h1 : (i == 1) ? 4'h3 : (i == 3) ? 4'hf : 4'h0);
			check(geometry_ok_o, i inside {0, 1, 3});
			wr(8'hde, {3'h0, i[1:0], 3'h0});
			check(geometry_ok_o, i[1:0] == 2'h0);
			wr(8'hde, {5'h00, i[2:0]});
			check(geometry_ok_o, i inside {0, 1, 3});
		end
		wr(8'hde, 8'h60);
		// lane 1 carries a table error, lane 2 a disparity error
		for (int m = 0; m < 4; m++) begin
			wr(8'hdb, {(m == 2) ? 4'h5 : 4'ha, 2'h0, m[1:0]});
			p = mk(16'(m * 256));
			e = mk(16'(m * 256 + 128));
			far.send(p);
			far.send(e, 8'h04, 8'h10);
			x = e;
			if (!m[0]) x[31:16] = p[31:16];
			if (!m[1]) x[47:32] = p[47:32];
			pop({4'h0, p});
			pop({(m == 0) ? 4'h2 : 4'h0, x});
		end
		wr(8'hdb, 8'h08);
		p = mk(16'h1000);
		e = mk(16'h2000);
		x = mk(16'h3000);
		far.send(p);
		far.send(e);
		far.send(x, 8'h00, 8'h01);
		pop({4'h0, p});
		pop({4'h0, e});
		pop({4'h0, x[63:16], p[15:0]});
		@(posedge clk_i);
		sample_ready_i <= 1'b0;
		fork
			begin
				far.send(p);
				far.send(e);
				far.send(x);
			end
			begin
				repeat (300) @(posedge clk_i);
				check(link_ready_o, 1'b0);
				sample_ready_i <= 1'b1;
			end
		join
		pop({4'h0, p});
		pop({4'h0, e});
		pop({4'h0, x});
		wr(8'hdc, 8'h10);
		far.send(p, 8'h00, 8'h00, 8'h00, 4'h3);
		pop({4'h0, p});
		repeat (20) @(posedge clk_i);
		check(racc, 4'h1);
		wr(8'hdc, 8'h06);
		x = {16'h0, 16'hbc00, 16'h0, 16'h00bc};
		far.send(x, 8'h00, 8'h00, 8'h21);
		pop({4'h0, x});
		repeat (20) @(posedge clk_i);
		check(sacc, 4'h4);
		wr(8'hdd, 8'h00);
		repeat (40) @(posedge clk_i);
		check(cdn, 0);
		wr(8'hdd, 8'h80);
		for (int n = 0; n < 100 && cdn == 0; n++) @(posedge clk_i);
		check(cdn, 1);
		check(capture_sample_o, x);
		rchk(8'hdd, 8'h00);
		give_verdict();
	end
endmodule
